//--- logic/twi_slave_pkg.sv
// Shared constants, types and register map of the two-wire slave receiver
package twi_slave_pkg;
    // APB byte offsets
    localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
    localparam logic [7:0] OFS_CONTROL  = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_DATA     = 8'h0c;
    // control_reg field positions
    localparam int CTL_IRQ_FLAG  = 7;
    localparam int CTL_ACK_EN    = 6;
    localparam int CTL_START_REQ = 5;
    localparam int CTL_STOP_REQ  = 4;
    localparam int CTL_WCOL      = 3;
    localparam int CTL_IFACE_EN  = 2;
    localparam int CTL_IRQ_EN    = 0;
    // own_address_reg and status_reg field positions
    localparam int OWN_GCE       = 0;
    localparam int STS_CODE_LSB  = 3;
    // Reset values
    localparam logic [7:0] RST_OWN_ADDR = 8'h00;
    localparam logic [7:0] RST_CONTROL  = 8'h00;
    localparam logic [7:0] RST_DATA     = 8'hff;
    localparam logic [1:0] RST_PRESC    = 2'h0;
    // Status codes, prescaler bits masked to zero
    localparam logic [7:0] SC_OWN_W      = 8'h60;
    localparam logic [7:0] SC_ARB_OWN_W  = 8'h68;
    localparam logic [7:0] SC_GEN_CALL   = 8'h70;
    localparam logic [7:0] SC_ARB_GC     = 8'h78;
    localparam logic [7:0] SC_DATA_ACK   = 8'h80;
    localparam logic [7:0] SC_DATA_NACK  = 8'h88;
    localparam logic [7:0] SC_GC_ACK     = 8'h90;
    localparam logic [7:0] SC_GC_NACK    = 8'h98;
    localparam logic [7:0] SC_STOP_RSTART = 8'ha0;
    localparam logic [7:0] SC_NO_INFO    = 8'hf8;
    // Bus constants
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic       DIR_WRITE     = 1'b0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int         SYNC_STAGES   = 2;

    // Wire levels of the bus, kept together
    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

    // Bus events found by sampling the wires
    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } bus_cond_t;

    // Receiver states, Gray codes in listed order
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_ADDR     = 3'b001,
        ST_ADDR_ACK = 3'b011,
        ST_DATA     = 3'b010,
        ST_DATA_ACK = 3'b110,
        ST_WAIT     = 3'b111,
        ST_SKIP     = 3'b101
    } rx_state_t;
endpackage

//--- logic/twi_pin_sync.sv
// Two-flop synchroniser for the bus wires
`timescale 1ns/100ps
module twi_pin_sync
    import twi_slave_pkg::*;
(
    input  wire logic      CLK,   // System clock
    input  wire logic      RST_N, // Synchronous reset, active low
    input  wire bus_pins_t D,     // Raw wire levels
    output bus_pins_t      Q      // Synchronised levels
);
    bus_pins_t meta;

    // First stage feeds only the second; idle bus reads high after reset
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            meta <= '1;
            Q    <= '1;
        end
        else
        begin
            meta <= D;
            Q    <= meta;
        end
    end
endmodule

//--- logic/twi_bus_cond.sv
// Edge, START and STOP detection on synchronised bus wires
`timescale 1ns/100ps
module twi_bus_cond
    import twi_slave_pkg::*;
(
    input  wire logic      CLK,   // System clock
    input  wire logic      RST_N, // Synchronous reset, active low
    input  wire bus_pins_t PINS,  // Synchronised wire levels
    output bus_cond_t      COND   // One-cycle bus events
);
    bus_pins_t prev;

    // Previous sample, idle-high after reset
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            prev <= '1;
        else
            prev <= PINS;
    end

    // SDA moving while SCL stays high marks START or STOP
    always_comb
    begin
        COND.scl_rise = PINS.scl & ~prev.scl;
        COND.scl_fall = ~PINS.scl & prev.scl;
        COND.start    = PINS.scl & prev.scl & prev.sda & ~PINS.sda;
        COND.stop     = PINS.scl & prev.scl & ~prev.sda & PINS.sda;
    end
endmodule

//--- logic/twi_slave_rx.sv
// Two-wire slave receiver with APB register access
// Behaviour
// - Match own 7-bit address; general call if enabled
// - Write direction receives; read direction left unserved
// - Own address plus write sets flag and status
// - Own address write acknowledged reports 0x60
// - Addressed after lost arbitration reports 0x68/0x78
// - General call acknowledged reports 0x70
// - Acknowledged data reports 0x80, byte in data_reg
// - Unacknowledged data reports 0x88
// - After 0x88 flag clear leaves addressed state
// - Start request then sends START when bus free
// - Flag clear receives next byte, ack per enable
// - Ack enable cleared: next byte gets NOT ACK
// - Ack enable low ignores own address, keeps monitoring
// - Address match in deep sleep wakes the chip
// - After wake, SCL held low until flag cleared
// - Data register not refreshed while asleep
// - General call data reports 0x90 or 0x98
// - STOP or repeated START while addressed reports 0xA0
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
module twi_slave_rx
    import twi_slave_pkg::*;
(
    input  wire logic        CLK,       // System clock, 125 MHz
    input  wire logic        RST_N,     // Synchronous reset, active low
    input  wire logic        PSEL,      // APB select
    input  wire logic        PENABLE,   // APB access phase
    input  wire logic        PWRITE,    // APB direction
    input  wire logic [7:0]  PADDR,     // APB byte address
    input  wire logic [31:0] PWDATA,    // APB write data
    output logic      [31:0] PRDATA,    // APB read data
    output logic             PREADY,    // APB ready
    output logic             PSLVERR,   // APB error on unmapped address
    input  wire logic        SCL_I,     // SCL wire level
    output logic             SCL_O,     // SCL drive value, always low
    output logic             SCL_OE,    // Low while pulling SCL low
    input  wire logic        SDA_I,     // SDA wire level
    output logic             SDA_O,     // SDA drive value, always low
    output logic             SDA_OE,    // Low while pulling SDA low
    input  wire logic        SLEEP,     // Chip in a sleep mode other than idle
    input  wire logic        ARB_LOST,  // Master part lost arbitration
    output logic             WAKE,      // Wake request after address match
    output logic             START_REQ, // Pulse: master part may send START
    output logic             IRQ        // Flag gated by interrupt enable
);
    bus_pins_t pins_raw;
    bus_pins_t pins;
    bus_cond_t cond;
    rx_state_t state;
    logic [7:0] own_address_reg;
    logic [7:0] control_reg;
    logic [7:0] data_reg;
    logic [7:0] code;
    logic [1:0] presc;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic       gen_call;
    logic       nack_byte;
    logic       ack_drive;
    logic       stretch;
    logic       bus_busy;
    logic       start_pending;
    logic       set_flag;
    logic [7:0] next_code;
    logic       setup;
    logic       wr;
    logic       flag_clear;
    logic       addr_match;

    // Address decode used by the write strobe and by the error response
    function automatic logic mapped(input logic [7:0] a);
        return a == OFS_OWN_ADDR || a == OFS_CONTROL || a == OFS_STATUS || a == OFS_DATA;
    endfunction

    // Raw wires enter the synchroniser as one word
    assign pins_raw = {SCL_I, SDA_I};

    twi_pin_sync u_sync (
        .CLK   (CLK),
        .RST_N (RST_N),
        .D     (pins_raw),
        .Q     (pins)
    );

    twi_bus_cond u_cond (
        .CLK   (CLK),
        .RST_N (RST_N),
        .PINS  (pins),
        .COND  (cond)
    );

    // APB strobes; zero wait states, so ready is constant high
    assign setup      = PSEL & ~PENABLE;
    assign wr         = PSEL & PENABLE & PWRITE & mapped(PADDR);
    assign flag_clear = wr && PADDR == OFS_CONTROL && PWDATA[CTL_IRQ_FLAG] && control_reg[CTL_IRQ_FLAG];
    assign PREADY     = 1'b1;
    assign PSLVERR    = PSEL & PENABLE & ~mapped(PADDR);

    // Match on the completed address byte
    assign addr_match = control_reg[CTL_ACK_EN] &&
                        (shift[7:1] == own_address_reg[7:1] ||
                         (shift[7:1] == GEN_CALL_ADDR && own_address_reg[OWN_GCE]));

    // Open-drain pins: value low, enable low pulls the wire
    assign SCL_O  = 1'b0;
    assign SDA_O  = 1'b0;
    assign SCL_OE = ~stretch;
    assign SDA_OE = ~ack_drive;
    assign IRQ    = control_reg[CTL_IRQ_FLAG] & control_reg[CTL_IRQ_EN];

    // Read data is captured in the setup phase so it comes from a flop
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            PRDATA <= '0;
        else if (setup)
        begin
            unique case (PADDR)
                OFS_OWN_ADDR: PRDATA <= {24'h000000, own_address_reg};
                OFS_CONTROL:  PRDATA <= {24'h000000, control_reg};
                OFS_STATUS:   PRDATA <= {24'h000000, code[7:STS_CODE_LSB], 1'b0, presc};
                OFS_DATA:     PRDATA <= {24'h000000, data_reg};
                default:      PRDATA <= '0;
            endcase
        end
    end

    // Own address and prescaler bits are plain storage
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            own_address_reg <= RST_OWN_ADDR;
            presc           <= RST_PRESC;
        end
        else if (wr && PADDR == OFS_OWN_ADDR)
            own_address_reg <= PWDATA[7:0];
        else if (wr && PADDR == OFS_STATUS)
            presc <= PWDATA[1:0];
    end

    // Control: flag is write-one-to-clear and a hardware set wins
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            control_reg <= RST_CONTROL;
        else
        begin
            if (wr && PADDR == OFS_CONTROL)
            begin
                control_reg[CTL_ACK_EN]    <= PWDATA[CTL_ACK_EN];
                control_reg[CTL_START_REQ] <= PWDATA[CTL_START_REQ];
                control_reg[CTL_STOP_REQ]  <= PWDATA[CTL_STOP_REQ];
                control_reg[CTL_IFACE_EN]  <= PWDATA[CTL_IFACE_EN];
                control_reg[CTL_IRQ_EN]    <= PWDATA[CTL_IRQ_EN];
            end
            // Data write while the flag is low is a collision
            if (wr && PADDR == OFS_DATA)
                control_reg[CTL_WCOL] <= ~control_reg[CTL_IRQ_FLAG];
            if (set_flag)
                control_reg[CTL_IRQ_FLAG] <= 1'b1;
            else if (flag_clear)
                control_reg[CTL_IRQ_FLAG] <= 1'b0;
        end
    end

    // Status code follows each flag set, data register each data byte received while awake
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            code     <= SC_NO_INFO;
            data_reg <= RST_DATA;
        end
        else
        begin
            if (set_flag)
                code <= next_code;
            else if (flag_clear)
                code <= SC_NO_INFO;
            // Byte lands only while awake; after a wake the register is stale
            if (state == ST_DATA_ACK && cond.scl_fall && !SLEEP)
                data_reg <= shift;
            else if (wr && PADDR == OFS_DATA && control_reg[CTL_IRQ_FLAG])
                data_reg <= PWDATA[7:0];
        end
    end

    // Flag events and their status codes
    always_comb
    begin
        set_flag  = 1'b0;
        next_code = SC_NO_INFO;
        if (control_reg[CTL_IFACE_EN])
        begin
            if ((cond.start || cond.stop) && (state == ST_DATA || state == ST_DATA_ACK))
            begin
                set_flag  = 1'b1;
                next_code = SC_STOP_RSTART;
            end
            else if (state == ST_ADDR_ACK && cond.scl_fall)
            begin
                set_flag = 1'b1;
                if (gen_call)
                    next_code = ARB_LOST ? SC_ARB_GC : SC_GEN_CALL;
                else
                    next_code = ARB_LOST ? SC_ARB_OWN_W : SC_OWN_W;
            end
            else if (state == ST_DATA_ACK && cond.scl_fall)
            begin
                set_flag = 1'b1;
                if (gen_call)
                    next_code = nack_byte ? SC_GC_NACK : SC_GC_ACK;
                else
                    next_code = nack_byte ? SC_DATA_NACK : SC_DATA_ACK;
            end
        end
    end

    // Bus busy tracking and deferred START request to the master part
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            bus_busy      <= 1'b0;
            start_pending <= 1'b0;
            START_REQ     <= 1'b0;
        end
        else
        begin
            if (cond.start)
                bus_busy <= 1'b1;
            else if (cond.stop)
                bus_busy <= 1'b0;
            START_REQ <= 1'b0;
            // The request bit is written together with the flag clear, so the written value counts
            if (state == ST_WAIT && flag_clear && nack_byte && PWDATA[CTL_START_REQ])
                start_pending <= 1'b1;
            else if (code == SC_STOP_RSTART && flag_clear && PWDATA[CTL_START_REQ])
                start_pending <= 1'b1;
            else if (start_pending && !bus_busy)
            begin
                start_pending <= 1'b0;
                START_REQ     <= 1'b1;
            end
        end
    end

    // Wake request from an address match in sleep, dropped on flag clear
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            WAKE <= 1'b0;
        else if (state == ST_ADDR && cond.scl_fall && bit_cnt == BITS_PER_BYTE &&
                 addr_match && shift[0] == DIR_WRITE && SLEEP)
            WAKE <= 1'b1;
        else if (flag_clear)
            WAKE <= 1'b0;
    end

    // Receiver sequence; START and STOP take priority over bit events
    always_ff @(posedge CLK)
    begin
        if (!RST_N || !control_reg[CTL_IFACE_EN])
        begin
            state     <= ST_IDLE;
            shift     <= '0;
            bit_cnt   <= '0;
            gen_call  <= 1'b0;
            nack_byte <= 1'b0;
            ack_drive <= 1'b0;
            stretch   <= 1'b0;
        end
        else if (cond.start)
        begin
            state     <= ST_ADDR;
            bit_cnt   <= '0;
            ack_drive <= 1'b0;
        end
        else if (cond.stop)
        begin
            state     <= ST_IDLE;
            ack_drive <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE, ST_SKIP:
                    ack_drive <= 1'b0;
                ST_ADDR, ST_DATA:
                begin
                    if (cond.scl_rise && bit_cnt != BITS_PER_BYTE)
                    begin
                        shift   <= {shift[6:0], pins.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    else if (cond.scl_fall && bit_cnt == BITS_PER_BYTE)
                    begin
                        if (state == ST_ADDR)
                        begin
                            // Read direction belongs to the transmitter, not served here
                            if (addr_match && shift[0] == DIR_WRITE)
                            begin
                                ack_drive <= 1'b1;
                                gen_call  <= shift[7:1] == GEN_CALL_ADDR;
                                state     <= ST_ADDR_ACK;
                            end
                            else
                                state <= ST_SKIP;
                        end
                        else
                        begin
                            // Ack enable is sampled at the byte end
                            ack_drive <= control_reg[CTL_ACK_EN];
                            nack_byte <= ~control_reg[CTL_ACK_EN];
                            state     <= ST_DATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_DATA_ACK:
                    if (cond.scl_fall)
                    begin
                        ack_drive <= 1'b0;
                        stretch   <= 1'b1;
                        state     <= ST_WAIT;
                    end
                ST_WAIT:
                    if (flag_clear)
                    begin
                        stretch <= 1'b0;
                        bit_cnt <= '0;
                        state   <= nack_byte ? ST_IDLE : ST_DATA;
                        if (nack_byte)
                            nack_byte <= 1'b0;
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    AST_GC_NEEDS_ENABLE: assert property (
        state == ST_ADDR && cond.scl_fall && bit_cnt == BITS_PER_BYTE && shift[7:1] == GEN_CALL_ADDR &&
        own_address_reg[7:1] != GEN_CALL_ADDR && !own_address_reg[OWN_GCE] && !cond.start && !cond.stop
        |=> state != ST_ADDR_ACK)
        else $error("general call accepted while disabled");
    AST_NO_ADDR_ACK_WHEN_OFF: assert property (
        state == ST_ADDR && !control_reg[CTL_ACK_EN] |=> !ack_drive)
        else $error("address acknowledged with ack enable low");
    AST_OWN_W_STATUS: assert property (
        $rose(control_reg[CTL_IRQ_FLAG]) && code == SC_OWN_W |-> $past(state) == ST_ADDR_ACK && !$past(gen_call))
        else $error("0x60 without own address phase");
    AST_STRETCH_WHILE_FLAG: assert property (
        state == ST_WAIT && control_reg[CTL_IRQ_FLAG] |-> !SCL_OE)
        else $error("SCL released while flag set");
    AST_NACK_LEAVES: assert property (
        state == ST_WAIT && flag_clear && code == SC_DATA_NACK && !cond.start && !cond.stop
        |=> state == ST_IDLE)
        else $error("still addressed after 0x88 clear");
    AST_DATA_BYTE: assert property (
        $rose(control_reg[CTL_IRQ_FLAG]) && code == SC_DATA_ACK && !$past(SLEEP) |-> data_reg == $past(shift))
        else $error("data register does not hold byte");
    AST_NACK_AFTER_DISABLE: assert property (
        state == ST_DATA && cond.scl_fall && bit_cnt == BITS_PER_BYTE && !control_reg[CTL_ACK_EN] &&
        !cond.start && !cond.stop |=> SDA_OE ##1 (SDA_OE || state != ST_DATA_ACK))
        else $error("ack driven with ack enable low");
    AST_START_WHEN_FREE: assert property (
        start_pending && !bus_busy && !flag_clear |=> START_REQ)
        else $error("START not requested on free bus");
    AST_WAKE_HOLDS_SCL: assert property (
        WAKE && state == ST_WAIT |-> !SCL_OE && control_reg[CTL_IRQ_FLAG])
        else $error("SCL released during wake");
    AST_STOP_STATUS: assert property (
        control_reg[CTL_IFACE_EN] && cond.stop && state == ST_DATA |=> code == SC_STOP_RSTART && state == ST_IDLE)
        else $error("STOP while addressed not reported");
endmodule

//--- bench/twi_mst.sv
// Behavioural two-wire master transmitter on the far side of the bus
`timescale 1ns/100ps
module twi_mst
(
    input  wire logic scl,           // SCL wire level
    input  wire logic sda,           // SDA wire level
    output logic      scl_oe = 1'b1, // Low while pulling SCL low
    output logic      sda_oe = 1'b1  // Low while pulling SDA low
);
    // START from idle, or repeated START from the low phase
    task automatic start_c();
        sda_oe = 1'b1;
        #32;
        scl_oe = 1'b1;
        wait (scl === 1'b1);
        #32;
        sda_oe = 1'b0;
        #32;
        scl_oe = 1'b0;
    endtask
    // SDA moves 8 ns after SCL falls so it never looks like START or STOP
    task automatic bit_c(input logic v, output logic s);
        #8;
        sda_oe = v;
        #24;
        scl_oe = 1'b1;
        wait (scl === 1'b1); // A stretching slave may hold us here
        #32;
        s = sda;
        scl_oe = 1'b0;
    endtask
    // Byte MSB first, ninth clock reads the acknowledge
    task automatic put_byte(input logic [7:0] d, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_c(d[i], s);
        bit_c(1'b1, ack_n);
    endtask
    // STOP, then the clock stands still with both wires released
    task automatic stop_c();
        #8;
        sda_oe = 1'b0;
        #24;
        scl_oe = 1'b1;
        wait (scl === 1'b1);
        #32;
        sda_oe = 1'b1;
        #32;
    endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the two-wire slave receiver
`timescale 1ns/100ps
module tb_top;
    import twi_slave_pkg::*;
    typedef struct packed {logic [31:0] e; logic [31:0] m; logic err;} note_t;
    localparam logic [7:0] RUN = 8'hc5; // Clear flag; ack, interface, irq on
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0, arb = 1'b0;
    logic [7:0]  paddr = 8'h00, pwdata = 8'h00, b;
    logic [31:0] seed = 32'h070e63cd, prdata;
    logic [6:0]  own;
    logic        pready, pslverr, scl_oe, sda_oe, scl_o, sda_o, m_scl_oe, m_sda_oe, wake, start_req, irq;
    wire         scl = (scl_oe | scl_o) & m_scl_oe; // Pulled-up wired-AND; slave pulls only a low value
    wire         sda = (sda_oe | sda_o) & m_sda_oe;
    note_t       q[$];
    int          n_fail = 0, num_checks = 0, n_sr = 0;

    twi_slave_rx u_twi_slave_rx (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA({24'h0, pwdata}), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SCL_I(scl), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .SLEEP(sleep),
        .ARB_LOST(arb), .WAKE(wake), .START_REQ(start_req), .IRQ(irq));
    twi_mst u_twi_mst (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

    // 125 MHz system clock
    initial forever #4 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(logic [7:0] a, logic w, logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hff, logic err = 1'b0);
        q.push_back('{{24'h0, e}, {24'hffffff, m}, err});
        apb(a, 1'b0, 8'h00);
    endtask
    // Wait for the stretch, then the status code with prescaler masked
    task automatic hold(logic [7:0] code);
        for (int i = 0; i < 500 && scl_oe !== 1'b0; i++)
            @(posedge clk);
        repeat (8) @(posedge clk);
        check("scl_oe", 32'(scl_oe), 32'h0);
        check("irq", 32'(irq), 32'h1);
        rd(OFS_STATUS, code, 8'hfc);
    endtask
    task automatic xfer(logic [7:0] d, logic ack_n, logic [7:0] code);
        logic s;
        u_twi_mst.put_byte(d, s);
        check("ack", 32'(s), 32'(ack_n));
        if (code != 8'h00)
            hold(code);
    endtask
    task automatic fin(logic addressed);
        u_twi_mst.stop_c();
        repeat (12) @(posedge clk);
        if (addressed)
        begin
            rd(OFS_STATUS, SC_STOP_RSTART, 8'hfc);
            apb(OFS_CONTROL, 1'b1, RUN);
        end
    endtask

    // Each finished read takes the oldest note; start pulses are counted
    always @(posedge clk)
    begin
        if (psel && penable && pready && !pwrite && q.size() > 0)
        begin
            check("prdata", prdata & q[0].m, q[0].e);
            check("pslverr", 32'(pslverr), 32'(q[0].err));
            void'(q.pop_front());
        end
        if (start_req === 1'b1)
            n_sr++;
    end

    // Whole run is some tens of microseconds
    initial
    begin
        #300000;
        n_fail++;
        conclude();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        own = 7'(rnd() | 32'h1);
        rd(OFS_OWN_ADDR, RST_OWN_ADDR);
        rd(OFS_CONTROL, RST_CONTROL);
        rd(OFS_STATUS, SC_NO_INFO);
        rd(OFS_DATA, RST_DATA);
        rd(8'h10, 8'h00, 8'hff, 1'b1);
        apb(OFS_DATA, 1'b1, 8'h5a);
        rd(OFS_CONTROL, 8'(1 << CTL_WCOL));
        rd(OFS_DATA, RST_DATA);
        apb(OFS_STATUS, 1'b1, 8'h03);
        rd(OFS_STATUS, SC_NO_INFO | 8'h03);
        apb(OFS_OWN_ADDR, 1'b1, {own, 1'b1});
        apb(OFS_CONTROL, 1'b1, 8'h45);
        $display("test registers done");
        // Own and general call, with and without lost arbitration
        for (int k = 0; k < 4; k++)
        begin
            arb <= k[1];
            b = 8'(rnd());
            u_twi_mst.start_c();
            xfer(k[0] ? 8'h00 : {own, DIR_WRITE}, 1'b0,
                 k[0] ? (k[1] ? SC_ARB_GC : SC_GEN_CALL) : (k[1] ? SC_ARB_OWN_W : SC_OWN_W));
            arb <= 1'b0;
            apb(OFS_CONTROL, 1'b1, RUN);
            xfer(b, 1'b0, k[0] ? SC_GC_ACK : SC_DATA_ACK);
            rd(OFS_DATA, b);
            apb(OFS_CONTROL, 1'b1, RUN);
            fin(1'b1);
        end
        $display("test addressing done");
        u_twi_mst.start_c();
        xfer({own, DIR_WRITE}, 1'b0, SC_OWN_W);
        apb(OFS_CONTROL, 1'b1, 8'h85);
        xfer(8'(rnd()), 1'b1, SC_DATA_NACK);
        apb(OFS_CONTROL, 1'b1, 8'ha5);
        fin(1'b0);
        check("start_req", n_sr, 1);
        u_twi_mst.start_c();
        xfer({own, DIR_WRITE}, 1'b1, 8'h00);
        apb(OFS_CONTROL, 1'b1, 8'h45);
        u_twi_mst.start_c();
        xfer({own, DIR_WRITE}, 1'b0, SC_OWN_W);
        apb(OFS_CONTROL, 1'b1, RUN);
        fin(1'b1);
        $display("test nack done");
        u_twi_mst.start_c();
        xfer(8'h00, 1'b0, SC_GEN_CALL);
        apb(OFS_CONTROL, 1'b1, 8'h85);
        xfer(8'(rnd()), 1'b1, SC_GC_NACK);
        apb(OFS_CONTROL, 1'b1, RUN);
        apb(OFS_OWN_ADDR, 1'b1, {own, 1'b0});
        u_twi_mst.start_c();
        xfer(8'h00, 1'b1, 8'h00);
        u_twi_mst.start_c();
        xfer({own, 1'b1}, 1'b1, 8'h00);
        fin(1'b0);
        $display("test refusals done");
        sleep <= 1'b1;
        u_twi_mst.start_c();
        xfer({own, DIR_WRITE}, 1'b0, SC_OWN_W);
        check("wake", 32'(wake), 32'h1);
        sleep <= 1'b0;
        apb(OFS_CONTROL, 1'b1, RUN);
        repeat (2) @(posedge clk);
        check("release", {30'h0, wake, scl_oe}, 32'h1);
        fin(1'b1);
        $display("test sleep done");
        conclude();
    end
endmodule
